// ### cei_pkg.sv
// package: register map, field positions and reset values of the event interrupt block
package cei_pkg;
   localparam int CEI_ADDR_W = 4;
   // byte offsets of the registers
   localparam logic [3:0] CEI_OFS_ENABLE = 4'h0;
   localparam logic [3:0] CEI_OFS_FLAGS = 4'h4;
   localparam logic [3:0] CEI_OFS_CLEAR = 4'h8;
   localparam logic [3:0] CEI_OFS_FORCE = 4'hC;
   // field positions
   localparam int CEI_BIT_INT = 0;
   localparam int CEI_BIT_CAP1 = 1;
   localparam int CEI_BIT_OVF = 5;
   localparam int CEI_BIT_PRD = 6;
   localparam int CEI_BIT_CMP = 7;
   localparam int CEI_NUM_CAP = 4;
   // writable event bits 7..1; bit 0 and 15..8 read as zero
   localparam logic [15:0] CEI_EVENT_MASK = 16'h00FE;
   localparam logic [15:0] CEI_RST_ENABLE = 16'h0000;
   localparam logic [15:0] CEI_RST_FLAGS = 16'h0000;
   localparam logic [31:0] CEI_UNMAPPED_DATA = 32'h0000_0000;
   // bus access walks through these steps
   typedef enum logic [1:0] {CEI_BUS_IDLE, CEI_BUS_ACK} cei_bus_e;
endpackage

// ### cei_event_gate.sv
// event qualifier: mode gating and one-shot blocking of raw event pulses
`timescale 1ns/1ps
`default_nettype none
module cei_event_gate
   import cei_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic aux_pwm_mode_i,
   input wire logic oneshot_mode_i,
   input wire logic oneshot_stop_i,
   input wire logic rearm_i,
   input wire logic compare_equal_event_i,
   input wire logic period_equal_event_i,
   input wire logic counter_overflow_event_i,
   input wire logic [CEI_NUM_CAP-1:0] capture_event_i,
   output logic [15:0] event_set_o
);
   logic blocked_q;
   logic blocked_d;

   // ------------------------------------------------------------
   // one-shot block state
   // ------------------------------------------------------------
   // stop count in one-shot capture holds events off until re-armed
   always_comb begin
      blocked_d = blocked_q;
      if (rearm_i || aux_pwm_mode_i || !oneshot_mode_i) begin
         blocked_d = 1'b0;
      end else if (oneshot_stop_i) begin
         blocked_d = 1'b1; // R18
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         blocked_q <= 1'b0;
      end else begin
         blocked_q <= blocked_d;
      end
   end

   // ------------------------------------------------------------
   // mode qualification
   // ------------------------------------------------------------
   // the stop event itself still passes; only later ones are held off
   always_comb begin
      event_set_o = 16'h0000;
      if (!blocked_q) begin
         event_set_o[CEI_BIT_CMP] = compare_equal_event_i && aux_pwm_mode_i; // R9
         event_set_o[CEI_BIT_PRD] = period_equal_event_i && aux_pwm_mode_i; // R10
         event_set_o[CEI_BIT_OVF] = counter_overflow_event_i; // R11
         event_set_o[CEI_BIT_CAP1 +: CEI_NUM_CAP] =
            aux_pwm_mode_i ? 4'h0 : capture_event_i; // R12
      end
   end

   a_block_holds: assert property ( // R18
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      blocked_q |-> event_set_o == 16'h0000)
      else $error("event passed while one-shot block active");
   a_pwm_caps_off: assert property ( // R12
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      aux_pwm_mode_i |-> event_set_o[4:1] == 4'h0)
      else $error("capture event passed in pwm mode");
   a_cap_cmp_off: assert property ( // R9 R10
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      !aux_pwm_mode_i |-> event_set_o[7:6] == 2'b00)
      else $error("compare or period event passed in capture mode");
endmodule
`default_nettype wire

// ### cei_flag_bank.sv
// flag bank: sticky event flags with set and clear paths; force enters through set
`timescale 1ns/1ps
`default_nettype none
module cei_flag_bank
   import cei_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic [WIDTH-1:0] set_i,
   input wire logic [WIDTH-1:0] clear_i,
   output logic [WIDTH-1:0] flags_o
);
   logic [WIDTH-1:0] flag_q;
   logic [WIDTH-1:0] flag_d;

   // ------------------------------------------------------------
   // per-bit sticky flags
   // ------------------------------------------------------------
   // set wins over clear so a coincident event is never lost
   generate
      for (genvar i = 0; i < WIDTH; i++) begin : g_flag
         always_comb begin
            flag_d[i] = set_i[i] | (flag_q[i] & ~clear_i[i]); // R20
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flag_q <= '0; // R14
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flags_o = flag_q;

   a_set_wins: assert property ( // R20
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (set_i != '0) |=> ((flag_q & $past(set_i)) == $past(set_i)))
      else $error("flag set lost");
   a_clear_drops: assert property ( // R15
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (clear_i != '0) |=> ((flag_q & $past(clear_i) & ~$past(set_i)) == '0))
      else $error("cleared flag still set");
endmodule
`default_nettype wire

// ### cei_top.sv
// top: capture-timer event interrupt logic with avalon-mm register slave
//
// Function
// (R1) enable bits only gate events onto the interrupt request
// (R2) events latch into flags regardless of enable
// (R3) force sets and clear drops any flag, ignoring enables; here force sets flags 7..1 only, never flag 0
// (R4) software: mask, stop, disable, program, clear, enable, restart, unmask
// (R5) enable bit 7 gates compare-equal event
// (R6) enable bit 6 gates period-equal event
// (R7) enable bit 5 gates counter-overflow event
// (R8) enable bits 4..1 gate capture events; 15..8 and 0 read zero
// (R9) flag 7 sets on compare-equal, only in pwm mode
// (R10) flag 6 sets on period-equal, only in pwm mode
// (R11) flag 5 sets on counter wrap, in both modes
// (R12) flags 4..1 set on capture events, only in capture mode
// (R13) flag 0 sets whenever an interrupt request is issued
// (R14) flags are read-only to writes and reset to zero
// (R15) clear bit one clears flag; zero no effect; reads zero
// (R16) clear bit 0 drops global flag, allowing a fresh request
// (R17) force bit one sets event flag; zero no effect; reads zero
// (R18) one-shot stop blocks further events until re-armed
// (R19) request rises when enabled flag set and global clear; holds
// (R20) event and clear in one cycle leaves the flag set
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module cei_top
   import cei_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // avalon-mm slave
   input wire logic [CEI_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // event sources from the timer core
   input wire logic aux_pwm_mode_i,
   input wire logic oneshot_mode_i,
   input wire logic oneshot_stop_i,
   input wire logic rearm_i,
   input wire logic compare_equal_event_i,
   input wire logic period_equal_event_i,
   input wire logic counter_overflow_event_i,
   input wire logic [CEI_NUM_CAP-1:0] capture_event_i,
   // interrupt request to the host interrupt controller
   output logic irq_o
);
   cei_bus_e bus_q;
   cei_bus_e bus_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic wait_q;
   logic wait_d;
   logic [15:0] enable_q;
   logic [15:0] enable_d;
   logic irq_q;
   logic irq_d;
   logic [15:0] event_set;
   logic [15:0] flag_set;
   logic [15:0] flag_clr;
   logic [15:0] flags;
   logic [15:0] wr_lo;
   logic wr_fire;
   logic raise;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // low 16 bits of a write under byte enables; upper lanes unused
   function automatic logic [15:0] lane_mask(input logic [3:0] be);
      return {{8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic hit(input logic [CEI_ADDR_W-1:0] a,
                                input logic [3:0] ofs);
      return a == ofs;
   endfunction

   // ------------------------------------------------------------
   // event qualification and flags
   // ------------------------------------------------------------
   cei_event_gate u_gate (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .aux_pwm_mode_i(aux_pwm_mode_i),
      .oneshot_mode_i(oneshot_mode_i),
      .oneshot_stop_i(oneshot_stop_i),
      .rearm_i(rearm_i),
      .compare_equal_event_i(compare_equal_event_i),
      .period_equal_event_i(period_equal_event_i),
      .counter_overflow_event_i(counter_overflow_event_i),
      .capture_event_i(capture_event_i),
      .event_set_o(event_set)
   );

   // a write is taken in the acknowledge cycle only, so it acts once
   assign wr_fire = (bus_q == CEI_BUS_ACK) && avs_write_i;
   assign wr_lo = avs_writedata_i[15:0] & lane_mask(avs_byteenable_i);

   // events latch regardless of enable; force adds event bits only
   always_comb begin
      flag_set = event_set; // R2
      if (wr_fire && hit(avs_address_i, CEI_OFS_FORCE)) begin
         flag_set = flag_set | (wr_lo & CEI_EVENT_MASK); // R3 R17
      end
      flag_set[CEI_BIT_INT] = raise; // R13
      flag_clr = 16'h0000;
      if (wr_fire && hit(avs_address_i, CEI_OFS_CLEAR)) begin
         flag_clr = wr_lo & (CEI_EVENT_MASK | 16'h0001); // R15 R16 R3
      end
   end

   cei_flag_bank #(.WIDTH(16)) u_flags (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .set_i(flag_set),
      .clear_i(flag_clr),
      .flags_o(flags)
   );

   // ------------------------------------------------------------
   // interrupt request
   // ------------------------------------------------------------
   // a new request only while the global flag is down, so software
   // must clear bit 0 to allow the next one
   assign raise = !flags[CEI_BIT_INT] &&
                  ((flags & enable_q & CEI_EVENT_MASK) != 16'h0000); // R1 R19

   always_comb begin
      irq_d = irq_q;
      if (raise) begin
         irq_d = 1'b1; // R19
      end else if (!flags[CEI_BIT_INT]) begin
         irq_d = 1'b0; // R16
      end
   end

   // ------------------------------------------------------------
   // enable register
   // ------------------------------------------------------------
   // bits 7..5 and 4..1 steer the request; reserved bits stay zero
   always_comb begin
      enable_d = enable_q;
      if (wr_fire && hit(avs_address_i, CEI_OFS_ENABLE)) begin
         enable_d = ((enable_q & ~lane_mask(avs_byteenable_i)) | wr_lo)
                    & CEI_EVENT_MASK; // R5 R6 R7 R8
      end
   end

   // ------------------------------------------------------------
   // bus slave: one wait cycle, then acknowledge
   // ------------------------------------------------------------
   // flags are read-only: writes to them are accepted and dropped
   always_comb begin
      bus_d = bus_q;
      wait_d = 1'b1;
      rdata_d = rdata_q;
      unique case (bus_q)
         CEI_BUS_IDLE: begin
            if (avs_read_i || avs_write_i) begin
               bus_d = CEI_BUS_ACK;
               wait_d = 1'b0;
               rdata_d = CEI_UNMAPPED_DATA;
               if (hit(avs_address_i, CEI_OFS_ENABLE)) begin
                  rdata_d = {16'h0000, enable_q};
               end else if (hit(avs_address_i, CEI_OFS_FLAGS)) begin
                  rdata_d = {16'h0000, flags}; // R14
               end
               // clear and force read as zero
            end
         end
         CEI_BUS_ACK: begin
            bus_d = CEI_BUS_IDLE;
            wait_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bus_q <= CEI_BUS_IDLE;
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
         enable_q <= CEI_RST_ENABLE;
         irq_q <= 1'b0;
      end else begin
         bus_q <= bus_d;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
         enable_q <= enable_d;
         irq_q <= irq_d;
      end
   end

   assign avs_waitrequest_o = wait_q;
   assign avs_readdata_o = rdata_q;
   assign irq_o = irq_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_raise;
      raise;
   endsequence
   sequence s_irq_up;
      irq_o && flags[CEI_BIT_INT];
   endsequence

   // global flag seen low for one cycle after software clears it
   sequence s_int_dropped;
      !flags[CEI_BIT_INT];
   endsequence

   // request path: rise, hold, fall and re-raise
   a_irq_raise_seq: assert property ( // R19
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      s_raise |=> s_irq_up)
      else $error("request or global flag missing after raise");
   a_irq_holds: assert property ( // R19
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (irq_o && flags[CEI_BIT_INT]) |=> irq_o)
      else $error("request dropped while global flag set");
   a_irq_falls: assert property ( // R16
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (!flags[CEI_BIT_INT] && !raise) |=> !irq_o)
      else $error("request stayed up with global flag clear");
   a_int_rise_cause: assert property ( // R13
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      $rose(flags[CEI_BIT_INT]) |-> $past(raise))
      else $error("global flag rose without a request");
   a_disabled_quiet: assert property ( // R1
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      ((flags & enable_q & CEI_EVENT_MASK) == 16'h0000 &&
       !flags[CEI_BIT_INT]) |=> !flags[CEI_BIT_INT])
      else $error("global flag set with no enabled source");
   // a pending enabled flag must bring the request straight back
   a_int_rearm: assert property ( // R16
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_fire && hit(avs_address_i, CEI_OFS_CLEAR) &&
       wr_lo[CEI_BIT_INT] && flags[CEI_BIT_INT] &&
       ((flags & ~wr_lo & enable_q & CEI_EVENT_MASK) != 16'h0000))
      |=> s_int_dropped ##1 s_irq_up)
      else $error("pending source did not re-raise the request");
   a_int_clear: assert property ( // R16
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_fire && hit(avs_address_i, CEI_OFS_CLEAR) && wr_lo[0] && !raise)
      |=> !flags[CEI_BIT_INT])
      else $error("global flag not cleared");
   // register side: enables, read-only flags, write-one clear and force
   a_enable_rsvd: assert property ( // R8
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (enable_q & ~CEI_EVENT_MASK) == 16'h0000)
      else $error("reserved enable bit set");
   a_enable_write: assert property ( // R5 R6 R7 R8
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_fire && hit(avs_address_i, CEI_OFS_ENABLE) && avs_byteenable_i[0])
      |=> enable_q[7:1] == $past(avs_writedata_i[7:1]))
      else $error("enable write did not land");
   a_flags_ro: assert property ( // R14
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_fire && hit(avs_address_i, CEI_OFS_FLAGS) &&
       event_set == 16'h0000 && !raise) |=> flags == $past(flags))
      else $error("write to flag register changed a flag");
   a_force_sets: assert property ( // R17
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_fire && hit(avs_address_i, CEI_OFS_FORCE) && wr_lo[CEI_BIT_CMP])
      |=> flags[CEI_BIT_CMP])
      else $error("force did not set flag");
   a_force_exact: assert property ( // R3 R17
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_fire && hit(avs_address_i, CEI_OFS_FORCE) &&
       event_set == 16'h0000)
      |=> flags[7:1] == $past(flags[7:1] | wr_lo[7:1]))
      else $error("force changed flags other than those written");
   a_clear_exact: assert property ( // R3 R15
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_fire && hit(avs_address_i, CEI_OFS_CLEAR) &&
       event_set == 16'h0000)
      |=> flags[7:1] == $past(flags[7:1] & ~wr_lo[7:1]))
      else $error("clear changed flags other than those written");
   a_wo_read_zero: assert property ( // R15 R17
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (bus_q == CEI_BUS_IDLE && avs_read_i &&
       (hit(avs_address_i, CEI_OFS_CLEAR) ||
        hit(avs_address_i, CEI_OFS_FORCE)))
      |=> avs_readdata_o == 32'h0000_0000)
      else $error("clear or force register read back nonzero");
   a_rdata_upper: assert property (
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      avs_readdata_o[31:16] == 16'h0000)
      else $error("upper half of read data not zero");
   // bus timing: exactly one acknowledge cycle per access
   a_wait_ack: assert property (
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (bus_q == CEI_BUS_IDLE && (avs_read_i || avs_write_i))
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus acknowledge not one cycle");
   // event path: overflow counts in both modes
   a_ovf_latch: assert property ( // R11
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      event_set[CEI_BIT_OVF] |=> flags[CEI_BIT_OVF])
      else $error("overflow not latched");
endmodule
`default_nettype wire

// ### cei_host_model.sv
// host model: avalon-mm master reaching the event interrupt registers
`timescale 1ns/1ps
`default_nettype none
module cei_host_model
   import cei_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic [31:0] avs_readdata_i,
   input wire logic avs_waitrequest_i,
   output logic [CEI_ADDR_W-1:0] avs_address_o,
   output logic avs_read_o,
   output logic avs_write_o,
   output logic [31:0] avs_writedata_o,
   output logic [3:0] avs_byteenable_o
);
   // bus idles quiet from time zero
   initial begin
      avs_address_o = 4'h0;
      avs_read_o = 1'b0;
      avs_write_o = 1'b0;
      avs_writedata_o = 32'h0000_0000;
      avs_byteenable_o = 4'h3;
   end
   // one access; the request holds until waitrequest is sampled low
   task automatic access(input logic wr, input logic [3:0] a,
      input logic [15:0] wd, output logic [31:0] rd);
      avs_address_o <= a;
      avs_writedata_o <= {16'h0000, wd};
      avs_write_o <= wr;
      avs_read_o <= !wr;
      @(posedge sys_clk_i);
      while (avs_waitrequest_i !== 1'b0) begin
         @(posedge sys_clk_i);
      end
      rd = avs_readdata_i;
      avs_read_o <= 1'b0;
      avs_write_o <= 1'b0;
      // idle edge so a following call never redrives in this step
      @(posedge sys_clk_i);
   endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// testbench: register, event, force, clear and one-shot checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cei_pkg::*;
   logic sys_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [3:0] addr;
   logic rd_en, wr_en, wreq, irq;
   logic [31:0] wdata, rdata_bus, rdata;
   logic [3:0] be;
   logic [7:1] ev_q = 7'h00;
   logic pwm_q = 1'b0, os_q = 1'b0, stop_q = 1'b0, rearm_q = 1'b0;
   int bad_count = 0;
   int tests_run = 0;
   // free-running 100 MHz clock
   always #5 sys_clk_i = ~sys_clk_i;
   cei_host_model h (.sys_clk_i(sys_clk_i), .avs_readdata_i(rdata_bus),
      .avs_waitrequest_i(wreq), .avs_address_o(addr), .avs_read_o(rd_en),
      .avs_write_o(wr_en), .avs_writedata_o(wdata),
      .avs_byteenable_o(be));
   cei_top i_dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
      .avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en),
      .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata_bus), .avs_waitrequest_o(wreq),
      .aux_pwm_mode_i(pwm_q), .oneshot_mode_i(os_q),
      .oneshot_stop_i(stop_q), .rearm_i(rearm_q),
      .compare_equal_event_i(ev_q[7]), .period_equal_event_i(ev_q[6]),
      .counter_overflow_event_i(ev_q[5]), .capture_event_i(ev_q[4:1]),
      .irq_o(irq));
   task automatic wrap_up();
      if (bad_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %0t read %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %0t irq %b expected %b", $time, g, e);
      end
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      h.access(1'b0, a, 16'h0000, rdata);
      chk32(rdata, {16'h0000, e});
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      h.access(1'b1, a, d, rdata);
   endtask
   // one-cycle event pulse on flag position b
   task automatic pulse(input int b);
      logic [7:0] t;
      t = 8'h01 << b;
      ev_q <= t[7:1];
      @(posedge sys_clk_i);
      ev_q <= 7'h00;
   endtask
   task automatic t_reset();
      rd_chk(CEI_OFS_ENABLE, 16'h0000);
      rd_chk(CEI_OFS_FLAGS, 16'h0000);
      rd_chk(CEI_OFS_CLEAR, 16'h0000);
      rd_chk(CEI_OFS_FORCE, 16'h0000);
      rd_chk(4'h2, 16'h0000);
      wr(CEI_OFS_ENABLE, 16'hFFFF);
      rd_chk(CEI_OFS_ENABLE, 16'h00FE);
      wr(CEI_OFS_ENABLE, 16'h0000);
      wr(CEI_OFS_FLAGS, 16'h00FF);
      rd_chk(CEI_OFS_FLAGS, 16'h0000);
   endtask
   // overflow in capture mode latches with its enable off
   task automatic t_latch();
      pulse(5);
      repeat (3) @(posedge sys_clk_i);
      chk1(irq, 1'b0);
      rd_chk(CEI_OFS_FLAGS, 16'h0020);
      wr(CEI_OFS_CLEAR, 16'h0000);
      rd_chk(CEI_OFS_FLAGS, 16'h0020);
      wr(CEI_OFS_CLEAR, 16'h0020);
      rd_chk(CEI_OFS_FLAGS, 16'h0000);
   endtask
   // each source: wrong mode ignored, right mode raises the request
   task automatic t_sources();
      logic [15:0] m;
      for (int b = 1; b <= 7; b++) begin
         m = 16'h0001 << b;
         if (b != 5) begin
            pwm_q <= (b < 5);
            @(posedge sys_clk_i);
            pulse(b);
            rd_chk(CEI_OFS_FLAGS, 16'h0000);
         end
         pwm_q <= (b >= 5);
         wr(CEI_OFS_ENABLE, m);
         pulse(b);
         repeat (3) @(posedge sys_clk_i);
         chk1(irq, 1'b1);
         rd_chk(CEI_OFS_FLAGS, m | 16'h0001);
         wr(CEI_OFS_ENABLE, 16'h0000);
         chk1(irq, 1'b1);
         wr(CEI_OFS_CLEAR, m | 16'h0001);
         @(posedge sys_clk_i);
         chk1(irq, 1'b0);
      end
      pwm_q <= 1'b0;
   endtask
   task automatic t_force();
      wr(CEI_OFS_FORCE, 16'h00FF);
      rd_chk(CEI_OFS_FLAGS, 16'h00FE);
      rd_chk(CEI_OFS_FORCE, 16'h0000);
      wr(CEI_OFS_CLEAR, 16'h00FE);
      rd_chk(CEI_OFS_FLAGS, 16'h0000);
      // pending enabled flag re-raises after the global flag is cleared
      wr(CEI_OFS_ENABLE, 16'h0002);
      wr(CEI_OFS_FORCE, 16'h0002);
      @(posedge sys_clk_i);
      wr(CEI_OFS_CLEAR, 16'h0001);
      rd_chk(CEI_OFS_FLAGS, 16'h0003);
      chk1(irq, 1'b1);
      wr(CEI_OFS_ENABLE, 16'h0000);
      wr(CEI_OFS_CLEAR, 16'h0003);
      @(posedge sys_clk_i);
      chk1(irq, 1'b0);
   endtask
   // capture event lands on the very edge that a clear takes effect
   task automatic t_collide();
      wr(CEI_OFS_FORCE, 16'h0002);
      fork
         wr(CEI_OFS_CLEAR, 16'h0002);
         begin
            @(posedge sys_clk_i);
            pulse(1);
         end
      join
      rd_chk(CEI_OFS_FLAGS, 16'h0002);
      wr(CEI_OFS_CLEAR, 16'h0002);
   endtask
   task automatic t_oneshot();
      os_q <= 1'b1;
      stop_q <= 1'b1;
      @(posedge sys_clk_i);
      stop_q <= 1'b0;
      @(posedge sys_clk_i);
      pulse(1);
      rd_chk(CEI_OFS_FLAGS, 16'h0000);
      rearm_q <= 1'b1;
      @(posedge sys_clk_i);
      rearm_q <= 1'b0;
      @(posedge sys_clk_i);
      pulse(1);
      rd_chk(CEI_OFS_FLAGS, 16'h0002);
      os_q <= 1'b0;
   endtask
   // reset in mid-run drops flags, enables and the request
   task automatic t_rst_mid();
      wr(CEI_OFS_ENABLE, 16'h0002);
      wr(CEI_OFS_FORCE, 16'h00FE);
      repeat (2) @(posedge sys_clk_i);
      chk1(irq, 1'b1);
      arst_n_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      chk1(irq, 1'b0);
      arst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_chk(CEI_OFS_FLAGS, 16'h0000);
      rd_chk(CEI_OFS_ENABLE, 16'h0000);
   endtask
   // watchdog: whole run is a few hundred cycles
   initial begin
      #100000;
      bad_count++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      t_reset();
      t_latch();
      t_sources();
      t_force();
      t_collide();
      t_oneshot();
      t_rst_mid();
      wrap_up();
   end
endmodule
`default_nettype wire
